// File: iwc_consts.svh
`ifndef IWC_CONSTS_SVH
`define IWC_CONSTS_SVH

// Register indices; byte address is four times the index
`define IWC_IDX_EDGE      8'hBF
`define IWC_IDX_FLAG      8'hC8
`define IWC_IDX_ENABLE    8'hC9
`define IWC_IDX_MODE      8'hCA
`define IWC_IDX_STACK     8'hDF

// Field positions
`define IWC_PIN_BIT       0
`define IWC_TMR_BIT       4
`define IWC_EDGE_FN_BIT   7
`define IWC_EDGE_SEL_LO   3
`define IWC_GIE_BIT       7
`define IWC_SLEEP_BIT     3

// Reset values
`define IWC_EDGE_RST      8'h00
`define IWC_FLAG_RST      2'h0
`define IWC_ENABLE_RST    2'h0
`define IWC_STACK_RST     3'h7
`define IWC_GIE_RST       1'b0
`define IWC_SLEEP_RST     1'b0

// Vector and timing
`define IWC_VECTOR        12'h008
`define IWC_WAKE_CLOCKS   2048

`endif

// File: iwc_pkg.sv
package iwc_pkg;

    typedef enum logic [1:0] {
        IWC_RUN   = 2'b00,
        IWC_SLEEP = 2'b01,
        IWC_WARM  = 2'b10
    } iwc_mode_t;

    typedef enum logic [1:0] {
        IWC_SEL_NONE = 2'b00,
        IWC_SEL_RISE = 2'b01,
        IWC_SEL_FALL = 2'b10,
        IWC_SEL_BOTH = 2'b11
    } iwc_edge_sel_t;

endpackage

// File: iwc_ctrl.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "iwc_consts.svh"

// What this block does
// (R1) Pin flag sets regardless of pin enable
// (R2) Vector only when source enable is set
// (R3) Accept loads vector 8, pushes one level
// (R4) Entry clears global enable, return sets it
// (R5) Global enable bit 7 gates service, resets 0
// (R6) Enable register: pin bit 0, timer bit 4
// (R7) Flag register pin bit 0, timer bit 4
// (R8) Software saves accumulator and flags itself
// (R9) Return instruction ends service routine
// (R10) Edge function off: low wake, falling irq
// (R11) Edge function on: select field, any change
// (R12) Edge select: reserved, rise, fall, both
// (R13) Sleep stops clocks, execution, timer, irqs
// (R14) Port level change leaves sleep
// (R15) Count 2048 oscillator clocks before running
// (R16) Pin trigger wakes from sleep
// (R17) Software writes sleep bit to enter sleep
// (R18) Timer flag sets on every overflow in run mode
// (R19) Mode bit: 0 normal, 1 sleep
// (R20) Accept only at instruction boundary
// (R21) Single common vector for all sources
module iwc_ctrl
    import iwc_pkg::*;
#(
    parameter int PC_W        = 12,
    parameter int P1_W        = 4,
    parameter int WAKE_CLOCKS = `IWC_WAKE_CLOCKS
) (
    input  wire logic            CORE_CLK_I,
    input  wire logic            RESET_N_I,
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [11:0]     PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic                 PREADY_O,
    output logic [31:0]          PRDATA_O,
    output logic                 PSLVERR_O,
    input  wire logic            INSTR_BOUNDARY_I,
    input  wire logic [PC_W-1:0] NEXT_PC_I,
    input  wire logic            RETURN_FROM_INTERRUPT_I,
    input  wire logic            TIMER_OVERFLOW_I,
    input  wire logic            PIN0_I,
    input  wire logic [P1_W-1:0] PORT1_I,
    output logic                 VECTOR_TAKE_O,
    output logic [PC_W-1:0]      VECTOR_PC_O,
    output logic [PC_W-1:0]      RETURN_ADDR_O,
    output logic                 STACK_PUSH_O,
    output logic                 STACK_POP_O,
    output logic                 CORE_RUN_O,
    output logic                 OSC_RUN_O
);

    if (PC_W < 4 || PC_W > 16 || P1_W < 1 || P1_W > 8 || WAKE_CLOCKS < 1
        || WAKE_CLOCKS > 4095 + 1) begin : g_bad_params
        $error("iwc_ctrl: unsupported parameter values");
    end

    localparam logic [11:0] WAKE_LAST = 12'(WAKE_CLOCKS - 1);

    iwc_mode_t     mode;
    logic [11:0]   wake_cnt;
    logic [1:0]    flag;
    logic [1:0]    enable;
    logic          edge_function_enable;
    iwc_edge_sel_t pin_edge_select;
    logic          global_irq_enable;
    logic [2:0]    stack_level_field;
    logic          sleep_mode_select;
    logic          pin0_prev;
    logic [P1_W-1:0] port1_prev;

    logic          access_done;
    logic          wr;
    logic [7:0]    idx;
    logic          mapped;
    logic [7:0]    rd_byte;
    logic          pin_rise;
    logic          pin_fall;
    logic          pin_trigger;
    logic          pin_wake;
    logic          port1_wake;
    logic          wake;
    logic          take;
    logic [1:0]    hw_set;

    // One wait state: ready rises on the second access cycle
    assign access_done = PSEL_I && PENABLE_I && PREADY_O;
    assign idx         = PADDR_I[9:2];
    assign wr          = access_done && PWRITE_I && mapped;

    always_comb begin
        mapped  = (PADDR_I[1:0] == 2'b00) && (PADDR_I[11:10] == 2'b00);
        rd_byte = 8'h00;
        case (idx)
            `IWC_IDX_EDGE: begin
                rd_byte[`IWC_EDGE_FN_BIT] = edge_function_enable;
                rd_byte[`IWC_EDGE_SEL_LO +: 2] = pin_edge_select;
            end
            `IWC_IDX_FLAG: begin
                rd_byte[`IWC_PIN_BIT] = flag[0]; // R7
                rd_byte[`IWC_TMR_BIT] = flag[1]; // R7
            end
            `IWC_IDX_ENABLE: begin
                rd_byte[`IWC_PIN_BIT] = enable[0]; // R6
                rd_byte[`IWC_TMR_BIT] = enable[1]; // R6
            end
            `IWC_IDX_MODE: begin
                rd_byte[`IWC_SLEEP_BIT] = sleep_mode_select;
            end
            `IWC_IDX_STACK: begin
                rd_byte[`IWC_GIE_BIT] = global_irq_enable;
                rd_byte[2:0] = stack_level_field;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
            PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !mapped;
            if (PSEL_I && PENABLE_I && !PREADY_O) begin
                PRDATA_O <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Pin 0 trigger decode
    assign pin_rise = PIN0_I && !pin0_prev;
    assign pin_fall = !PIN0_I && pin0_prev;

    always_comb begin
        if (!edge_function_enable) begin
            pin_trigger = pin_fall; // R10
            pin_wake    = !PIN0_I; // R10
            port1_wake  = !(&PORT1_I); // R10
        end else begin
            case (pin_edge_select) // R11 R12
                IWC_SEL_RISE: pin_trigger = pin_rise;
                IWC_SEL_FALL: pin_trigger = pin_fall;
                IWC_SEL_BOTH: pin_trigger = pin_rise || pin_fall;
                default:      pin_trigger = 1'b0;
            endcase
            pin_wake   = pin_trigger; // R11
            port1_wake = |(PORT1_I ^ port1_prev); // R11
        end
    end

    assign wake = (mode == IWC_SLEEP) && (pin_wake || port1_wake); // R14 R16

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pin0_prev  <= 1'b1;
            port1_prev <= '1;
        end else begin
            pin0_prev  <= PIN0_I;
            port1_prev <= PORT1_I;
        end
    end

    // Timer and pin events set no flags while asleep or warming
    assign hw_set[0] = pin_trigger && (mode == IWC_RUN); // R1 R13
    assign hw_set[1] = TIMER_OVERFLOW_I && (mode == IWC_RUN); // R18 R13

    for (genvar i = 0; i < 2; i++) begin : g_flag
        localparam int BIT = (i == 0) ? `IWC_PIN_BIT : `IWC_TMR_BIT;
        always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                flag[i]   <= 1'(`IWC_FLAG_RST >> i);
                enable[i] <= 1'(`IWC_ENABLE_RST >> i);
            end else begin
                if (hw_set[i]) begin
                    flag[i] <= 1'b1; // R1 R18
                end else if (wr && idx == `IWC_IDX_FLAG) begin
                    flag[i] <= PWDATA_I[BIT]; // R7
                end
                if (wr && idx == `IWC_IDX_ENABLE) begin
                    enable[i] <= PWDATA_I[BIT]; // R6
                end
            end
        end
    end

    assign take = (mode == IWC_RUN) && INSTR_BOUNDARY_I && global_irq_enable
                  && |(flag & enable); // R2 R5 R20 R21

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            edge_function_enable <= 1'(`IWC_EDGE_RST >> `IWC_EDGE_FN_BIT);
            pin_edge_select      <= iwc_edge_sel_t'(2'(`IWC_EDGE_RST >> `IWC_EDGE_SEL_LO));
        end else if (wr && idx == `IWC_IDX_EDGE) begin
            edge_function_enable <= PWDATA_I[`IWC_EDGE_FN_BIT];
            pin_edge_select      <= iwc_edge_sel_t'(PWDATA_I[`IWC_EDGE_SEL_LO +: 2]);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            global_irq_enable <= `IWC_GIE_RST; // R5
            stack_level_field <= `IWC_STACK_RST;
        end else begin
            if (take) begin
                global_irq_enable <= 1'b0; // R4
                stack_level_field <= stack_level_field - 3'h1; // R3
            end else if (RETURN_FROM_INTERRUPT_I && mode == IWC_RUN) begin
                global_irq_enable <= 1'b1; // R4 R9
                stack_level_field <= stack_level_field + 3'h1; // R9
            end else if (wr && idx == `IWC_IDX_STACK) begin
                global_irq_enable <= PWDATA_I[`IWC_GIE_BIT];
                stack_level_field <= PWDATA_I[2:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            VECTOR_TAKE_O <= 1'b0;
            VECTOR_PC_O   <= '0;
            RETURN_ADDR_O <= '0;
            STACK_PUSH_O  <= 1'b0;
            STACK_POP_O   <= 1'b0;
        end else begin
            VECTOR_TAKE_O <= take;
            STACK_PUSH_O  <= take; // R3
            STACK_POP_O   <= !take && RETURN_FROM_INTERRUPT_I && mode == IWC_RUN; // R9
            if (take) begin
                VECTOR_PC_O   <= PC_W'(`IWC_VECTOR); // R3 R21
                RETURN_ADDR_O <= NEXT_PC_I; // R20
            end
        end
    end

    // Power mode sequencing
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode              <= IWC_RUN;
            wake_cnt          <= 12'h000;
            sleep_mode_select <= `IWC_SLEEP_RST;
            CORE_RUN_O        <= 1'b1;
            OSC_RUN_O         <= 1'b1;
        end else begin
            case (mode)
                IWC_RUN: begin
                    if (wr && idx == `IWC_IDX_MODE) begin
                        sleep_mode_select <= PWDATA_I[`IWC_SLEEP_BIT]; // R17 R19
                        if (PWDATA_I[`IWC_SLEEP_BIT]) begin
                            mode       <= IWC_SLEEP; // R19
                            CORE_RUN_O <= 1'b0; // R13
                            OSC_RUN_O  <= 1'b0; // R13
                        end
                    end
                end
                IWC_SLEEP: begin
                    if (wake) begin
                        mode      <= IWC_WARM; // R14
                        wake_cnt  <= 12'h000;
                        OSC_RUN_O <= 1'b1;
                    end
                end
                IWC_WARM: begin
                    if (wake_cnt == WAKE_LAST) begin
                        mode              <= IWC_RUN; // R15
                        sleep_mode_select <= 1'b0;
                        CORE_RUN_O        <= 1'b1;
                    end else begin
                        wake_cnt <= wake_cnt + 12'h001; // R15
                    end
                end
                default: begin
                    mode <= IWC_RUN;
                end
            endcase
        end
    end

    // Checks
    logic [1:0] armed;
    assign armed = flag & enable;

    a_pin_flag_set: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R1
        hw_set[0] |=> flag[0]) else $error("pin flag not set");
    a_timer_flag_set: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R18
        (TIMER_OVERFLOW_I && mode == IWC_RUN) |=> flag[1]) else $error("timer flag not set");
    a_vector_gated: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R2
        VECTOR_TAKE_O |-> $past(armed) != 2'b00) else $error("vector without enabled flag");
    a_vector_needs_gie: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R5
        VECTOR_TAKE_O |-> $past(global_irq_enable)) else $error("vector with gie low");
    a_vector_addr: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R3
        VECTOR_TAKE_O |-> (VECTOR_PC_O == PC_W'(8)) && STACK_PUSH_O) else $error("bad vector");
    a_gie_cleared: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R4
        take |=> !global_irq_enable ##1 !VECTOR_TAKE_O) else $error("gie not cleared");
    a_gie_restored: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R9
        (RETURN_FROM_INTERRUPT_I && !take && mode == IWC_RUN) |=> global_irq_enable && STACK_POP_O)
        else $error("return did not restore gie");
    a_boundary_only: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R20
        VECTOR_TAKE_O |-> $past(INSTR_BOUNDARY_I) && (RETURN_ADDR_O == $past(NEXT_PC_I)))
        else $error("vector off boundary");
    a_sleep_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R13
        (mode == IWC_SLEEP) |-> !CORE_RUN_O && !OSC_RUN_O && !take) else $error("active in sleep");
    a_sleep_entry: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R17
        (wr && idx == `IWC_IDX_MODE && mode == IWC_RUN && PWDATA_I[`IWC_SLEEP_BIT])
        |=> mode == IWC_SLEEP) else $error("no sleep entry");
    a_wake_exit: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R14
        wake |=> mode == IWC_WARM && OSC_RUN_O && !CORE_RUN_O) else $error("no wake");
    a_warm_length: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // R15
        ($past(mode) == IWC_WARM && mode == IWC_RUN) |-> $past(wake_cnt) == WAKE_LAST)
        else $error("wrong wake count");

    c_vector: cover property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        VECTOR_TAKE_O ##[1:50] STACK_POP_O);
    c_wake: cover property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        mode == IWC_WARM ##1 mode == IWC_RUN);
    c_masked_flag: cover property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        flag[0] && !enable[0] && global_irq_enable);

endmodule

// File: iwc_core_model.sv
`timescale 1ns/1ns
module iwc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hold_i,
    input  wire logic        ret_go_i,
    input  wire logic        core_run_i,
    input  wire logic        take_i,
    input  wire logic [11:0] ret_addr_i,
    output logic             boundary_o,
    output logic [11:0]      next_pc_o,
    output logic             ret_o,
    output logic [11:0]      take_pc_o
);
    logic [11:0] pc_seen;

    // Two-cycle instructions; hold_i stretches one for as long as the bench wants
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boundary_o <= 1'b0;
        end else begin
            boundary_o <= core_run_i & ~hold_i & ~boundary_o;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            next_pc_o <= 12'h010;
            pc_seen   <= 12'h000;
            take_pc_o <= 12'h000;
        end else begin
            pc_seen <= next_pc_o;
            if (take_i) begin
                next_pc_o <= 12'h009;
                take_pc_o <= pc_seen;
            end else if (ret_o) begin
                next_pc_o <= ret_addr_i;
            end else if (boundary_o) begin
                next_pc_o <= next_pc_o + 12'h001;
            end
        end
    end

    // Service code keeps its own context; the return is a one-cycle pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ret_o <= 1'b0;
        end else begin
            ret_o <= ret_go_i;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
`include "iwc_consts.svh"
module tb_top;
    import iwc_pkg::*;
    localparam int W = 6;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, next_pc, vec_pc, ret_addr, take_pc;
    logic [31:0] pwdata, prdata, rd;
    logic        boundary, ret, tmr, pin, take, push, pop, core_run, osc_run;
    logic        hold, ret_go, err;
    logic [3:0]  port1;
    logic [7:0]  ectl;
    int          fail_count = 0;
    int          checked = 0;
    int          takes = 0;
    int          pushes = 0;
    int          pops = 0;

    iwc_ctrl #(.PC_W(12), .P1_W(4), .WAKE_CLOCKS(W)) dut (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .INSTR_BOUNDARY_I(boundary),
        .NEXT_PC_I(next_pc), .RETURN_FROM_INTERRUPT_I(ret), .TIMER_OVERFLOW_I(tmr),
        .PIN0_I(pin), .PORT1_I(port1), .VECTOR_TAKE_O(take), .VECTOR_PC_O(vec_pc),
        .RETURN_ADDR_O(ret_addr), .STACK_PUSH_O(push), .STACK_POP_O(pop),
        .CORE_RUN_O(core_run), .OSC_RUN_O(osc_run));

    iwc_core_model core (
        .clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .ret_go_i(ret_go),
        .core_run_i(core_run), .take_i(take), .ret_addr_i(ret_addr),
        .boundary_o(boundary), .next_pc_o(next_pc), .ret_o(ret), .take_pc_o(take_pc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (take === 1'b1) takes++;
        if (push === 1'b1) pushes++;
        if (pop === 1'b1) pops++;
    end

    task automatic finish_test();
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({err, rd}, {25'h0, exp});
    endtask

    task automatic settle_pin(input logic v);
        @(posedge clk);
        pin <= v;
        repeat (2) @(posedge clk);
    endtask

    task automatic tick();
        @(posedge clk);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic nap(input logic [7:0] ec, input logic p_pre, input logic p_trg,
                       input logic [3:0] q_pre, input logic [3:0] q_trg);
        int n;
        apb(1'b1, `IWC_IDX_EDGE, ec);
        pin   <= p_pre;
        port1 <= q_pre;
        apb(1'b1, `IWC_IDX_FLAG, 8'h00);
        apb(1'b1, `IWC_IDX_MODE, 8'h08);
        repeat (2) @(posedge clk);
        tick();
        @(negedge clk);
        chk(33'({core_run, osc_run}), 33'h0);
        @(posedge clk);
        pin   <= p_trg;
        port1 <= q_trg;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 2) chk(33'({core_run, osc_run}), 33'h1);
        end while (core_run !== 1'b1 && n < 100);
        chk(33'(n >= W + 2 && n <= W + 3), 33'h1);
        if (n >= 100) begin
            fail_count++;
            finish_test();
        end else begin
            rdc(`IWC_IDX_FLAG, 8'h00);
            rdc(`IWC_IDX_MODE, 8'h00);
        end
    endtask

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; tmr = 1'b0; pin = 1'b1; port1 = 4'hF; hold = 1'b0; ret_go = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`IWC_IDX_EDGE, 8'h00);
        rdc(`IWC_IDX_FLAG, 8'h00);
        rdc(`IWC_IDX_ENABLE, 8'h00);
        rdc(`IWC_IDX_STACK, 8'h07);
        rdc(`IWC_IDX_MODE, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk({err, rd}, 33'h1_0000_0000);
        // Pin trigger per select code, then with the edge function off
        for (int i = 0; i < 5; i++) begin
            ectl = (i < 4) ? {3'b100, 2'(i), 3'b000} : 8'h00;
            apb(1'b1, `IWC_IDX_EDGE, ectl);
            settle_pin(1'b0);
            apb(1'b1, `IWC_IDX_FLAG, 8'h00);
            settle_pin(1'b1);
            rdc(`IWC_IDX_FLAG, {7'h0, ectl[7] & ectl[3]});
            apb(1'b1, `IWC_IDX_FLAG, 8'h00);
            settle_pin(1'b0);
            rdc(`IWC_IDX_FLAG, {7'h0, ~ectl[7] | ectl[4]});
        end
        settle_pin(1'b1);
        apb(1'b1, `IWC_IDX_FLAG, 8'h00);
        apb(1'b1, `IWC_IDX_STACK, 8'h87);
        tick();
        rdc(`IWC_IDX_FLAG, 8'h10);
        chk(33'(takes), 33'h0);
        hold <= 1'b1;
        apb(1'b1, `IWC_IDX_FLAG, 8'h11);
        apb(1'b1, `IWC_IDX_ENABLE, 8'h11);
        repeat (8) @(posedge clk);
        chk(33'(takes), 33'h0);
        hold <= 1'b0;
        repeat (8) @(posedge clk);
        chk(33'(takes), 33'h1);
        chk(33'(pushes), 33'h1);
        chk(33'(vec_pc), 33'h8);
        chk(33'(ret_addr), 33'(take_pc));
        rdc(`IWC_IDX_STACK, 8'h06);
        rdc(`IWC_IDX_ENABLE, 8'h11);
        apb(1'b1, `IWC_IDX_ENABLE, 8'h00);
        apb(1'b1, `IWC_IDX_FLAG, 8'h00);
        rdc(`IWC_IDX_FLAG, 8'h00);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        repeat (4) @(posedge clk);
        chk(33'(pops), 33'h1);
        rdc(`IWC_IDX_STACK, 8'h87);
        nap(8'h00, 1'b1, 1'b1, 4'hF, 4'hE);
        nap(8'h88, 1'b0, 1'b1, 4'hF, 4'hF);
        nap(8'h80, 1'b1, 1'b1, 4'hD, 4'hF);
        chk(33'(takes), 33'h1);
        finish_test();
    end
endmodule
